/* File: hdl/pmlf_target.sv */
// Management bus target: strapped address, linear formats, PEC, alert and pacing guard
// What this block does
// - Target answers one address of 16 to 23, picked by strapping.
// - Three straps give address bits 0, 1, 2; grounded strap means zero.
// - Output-voltage format register at 20h reads 000 in bits 7:5.
// - Output voltage is 16-bit unsigned mantissa times two to 5-bit signed exponent.
// - Other quantities are 11-bit signed mantissa times 5-bit signed exponent.
// - Start-up time from input power is reported in ms with exponent 6.
// - Start-up time from remote control is reported in ms with exponent 2.
// - Set values live in non-volatile storage and return after power loss.
// - Alert output is asserted while the alarmActive input is high, one clock later.
// - Target checks and generates the optional packet error check byte.
`timescale 1ns/1ps
`default_nettype none

module pmlf_target
#(
    parameter int unsigned HOLDOFF_CYC = pmlf_pkg::HOLDOFF_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic strap_bit_zero,
    input wire logic strap_bit_one,
    input wire logic strap_bit_two,
    output logic alert_lineOut,
    output logic alert_lineOe,
    input wire logic alarmActive,
    input wire logic [15:0] startVinMs,
    input wire logic [15:0] startRcMs,
    input wire logic [15:0] nvmVoutStored,
    output logic nvmWrite,
    output logic [15:0] nvmWriteData,
    output logic [15:0] voutSetpoint
);
    import pmlf_pkg::*;

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    logic [1:0] sclSync_q, sdaSync_q;
    logic [1:0] strap0Sync_q, strap1Sync_q, strap2Sync_q;
    logic sclPrev_q, sdaPrev_q;
    logic sclS, sdaS, sclRise, sclFall, busStart, busStop;

    always_ff @(posedge clk_sys)
    begin
        sclSync_q <= {sclSync_q[0], sclIn};
        sdaSync_q <= {sdaSync_q[0], sdaIn};
        strap0Sync_q <= {strap0Sync_q[0], strap_bit_zero};
        strap1Sync_q <= {strap1Sync_q[0], strap_bit_one};
        strap2Sync_q <= {strap2Sync_q[0], strap_bit_two};
        sclPrev_q <= sclSync_q[1];
        sdaPrev_q <= sdaSync_q[1];
    end

    assign sclS = sclSync_q[1];
    assign sdaS = sdaSync_q[1];
    assign sclRise = sclS & ~sclPrev_q;
    assign sclFall = ~sclS & sclPrev_q;
    assign busStart = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
    assign busStop = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

    // ****************************************************************
    // Strapped address, caught once after reset release
    // ****************************************************************
    logic [2:0] strap_q;
    logic strapDone_q;
    logic [6:0] ownAddr;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            strap_q <= 3'h0;
            strapDone_q <= 1'b0;
        end
        else if (!strapDone_q)
        begin
            // Open strap reads high, grounded strap reads zero
            strap_q <= {strap2Sync_q[1], strap1Sync_q[1], strap0Sync_q[1]};
            strapDone_q <= 1'b1;
        end
    end

    assign ownAddr = {ADDR_BASE[6:3], strap_q};

    // ****************************************************************
    // Pacing guard after stop
    // ****************************************************************
    logic [15:0] guard_q;
    logic guardBusy;

    // A start inside the guard is ignored, so a hurried host simply sees no acknowledge
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            guard_q <= 16'h0000;
        else if (busStop)
            guard_q <= HOLDOFF_CYC[15:0];
        else if (guard_q != 16'h0000)
            guard_q <= guard_q - 16'h0001;
    end

    assign guardBusy = (guard_q != 16'h0000);

    // ****************************************************************
    // Readable values
    // ****************************************************************
    logic [15:0] voutSet_q;
    logic [7:0] crc_q;
    logic [7:0] cmd_q;
    logic [2:0] txIdx_q;
    logic [7:0] modeByte;
    logic [15:0] cmdWord;
    logic cmdIsWord;
    logic [7:0] txSel;

    assign modeByte = {VOUT_MODE_LINEAR, VOUT_EXP};

    always_comb
    begin
        cmdIsWord = 1'b1;
        unique case (cmd_q)
            CMD_VOUT_MODE:
            begin
                cmdWord = {8'h00, modeByte};
                cmdIsWord = 1'b0;
            end
            CMD_VOUT_COMMAND: cmdWord = voutSet_q;
            CMD_START_VIN: cmdWord = linPack(EXP_START_VIN, msToMant(startVinMs, EXP_START_VIN));
            CMD_START_RC: cmdWord = linPack(EXP_START_RC, msToMant(startRcMs, EXP_START_RC));
            default: cmdWord = NO_DATA;
        endcase
        // Low byte first, then high byte for words, then the check byte
        if (txIdx_q == 3'h0)
            txSel = cmdWord[7:0];
        else if (txIdx_q == 3'h1)
            txSel = cmdIsWord ? cmdWord[15:8] : crc_q;
        else if (txIdx_q == 3'h2 && cmdIsWord)
            txSel = crc_q;
        else
            txSel = NO_DATA[7:0];
    end

    // ****************************************************************
    // Byte engine
    // ****************************************************************
    pmlf_state_t state_q;
    logic [7:0] shReg_q, txByte_q, dataLo_q, dataHi_q;
    logic [2:0] bitCnt_q, byteIdx_q;
    logic readMode_q, ackOn_q, inFrame_q, crcOk_q, sdaOe_q;
    logic [7:0] rxByte;

    assign rxByte = {shReg_q[6:0], sdaS};

    // The target never stretches the clock; the host copes either way
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_q <= ST_IDLE;
            shReg_q <= 8'h00;
            txByte_q <= 8'h00;
            dataLo_q <= 8'h00;
            dataHi_q <= 8'h00;
            cmd_q <= 8'h00;
            bitCnt_q <= 3'h0;
            byteIdx_q <= IDX_ADDR;
            txIdx_q <= 3'h0;
            readMode_q <= 1'b0;
            ackOn_q <= 1'b0;
            inFrame_q <= 1'b0;
            crcOk_q <= 1'b0;
            crc_q <= CRC_INIT;
            sdaOe_q <= 1'b0;
        end
        else if (busStop)
        begin
            state_q <= ST_IDLE;
            inFrame_q <= 1'b0;
            sdaOe_q <= 1'b0;
            ackOn_q <= 1'b0;
        end
        else if (busStart)
        begin
            sdaOe_q <= 1'b0;
            ackOn_q <= 1'b0;
            bitCnt_q <= 3'h0;
            byteIdx_q <= IDX_ADDR;
            txIdx_q <= 3'h0;
            if (guardBusy && !inFrame_q)
                state_q <= ST_IDLE;
            else
            begin
                state_q <= ST_RX;
                inFrame_q <= 1'b1;
                // A repeated start keeps the running check value
                if (!inFrame_q)
                    crc_q <= CRC_INIT;
            end
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    sdaOe_q <= 1'b0;
                end
                ST_RX:
                begin
                    if (sclRise)
                    begin
                        shReg_q <= rxByte;
                        bitCnt_q <= bitCnt_q + 3'h1;
                        if (bitCnt_q == 3'h7)
                        begin
                            if (byteIdx_q != IDX_MAX)
                                byteIdx_q <= byteIdx_q + 3'h1;
                            if (byteIdx_q == IDX_ADDR)
                            begin
                                if (rxByte[7:1] == ownAddr)
                                begin
                                    readMode_q <= rxByte[0];
                                    crc_q <= crc8(crc_q, rxByte);
                                    state_q <= ST_RXACK;
                                end
                                else
                                    state_q <= ST_IDLE;
                            end
                            else
                            begin
                                if (byteIdx_q == IDX_CMD)
                                    cmd_q <= rxByte;
                                if (byteIdx_q == IDX_LO)
                                    dataLo_q <= rxByte;
                                if (byteIdx_q == IDX_HI)
                                    dataHi_q <= rxByte;
                                if (byteIdx_q == IDX_PEC)
                                    crcOk_q <= (crc8(crc_q, rxByte) == CRC_INIT);
                                crc_q <= crc8(crc_q, rxByte);
                                state_q <= ST_RXACK;
                            end
                        end
                    end
                end
                ST_RXACK:
                begin
                    if (sclFall)
                    begin
                        if (!ackOn_q)
                        begin
                            sdaOe_q <= 1'b1;
                            ackOn_q <= 1'b1;
                        end
                        else
                        begin
                            ackOn_q <= 1'b0;
                            bitCnt_q <= 3'h0;
                            if (readMode_q)
                            begin
                                state_q <= ST_TX;
                                txIdx_q <= 3'h1;
                                txByte_q <= {txSel[6:0], 1'b0};
                                crc_q <= crc8(crc_q, txSel);
                                sdaOe_q <= ~txSel[7];
                            end
                            else
                            begin
                                state_q <= ST_RX;
                                sdaOe_q <= 1'b0;
                            end
                        end
                    end
                end
                ST_TX:
                begin
                    if (sclFall)
                    begin
                        bitCnt_q <= bitCnt_q + 3'h1;
                        if (bitCnt_q == 3'h7)
                        begin
                            sdaOe_q <= 1'b0;
                            state_q <= ST_TXACK;
                        end
                        else
                        begin
                            sdaOe_q <= ~txByte_q[7];
                            txByte_q <= {txByte_q[6:0], 1'b0};
                        end
                    end
                end
                ST_TXACK:
                begin
                    if (sclRise && sdaS)
                        state_q <= ST_IDLE;
                    else if (sclFall)
                    begin
                        state_q <= ST_TX;
                        bitCnt_q <= 3'h0;
                        if (txIdx_q != IDX_MAX)
                            txIdx_q <= txIdx_q + 3'h1;
                        txByte_q <= {txSel[6:0], 1'b0};
                        crc_q <= crc8(crc_q, txSel);
                        sdaOe_q <= ~txSel[7];
                    end
                end
            endcase
        end
    end

    // txIdx_q counts the bytes sent in a read; every start clears it so a later read begins at byte zero
    // ****************************************************************
    // Set value commit and non-volatile image
    // ****************************************************************
    logic loadPend_q, nvmWrite_q, writeOk;

    // A write lands only at stop, and only when complete and, if a check byte came, correct
    assign writeOk = inFrame_q && !readMode_q && (cmd_q == CMD_VOUT_COMMAND)
                     && ((byteIdx_q == IDX_PEC) || ((byteIdx_q == IDX_AFTER_PEC) && crcOk_q));

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            voutSet_q <= VOUT_RESET;
            loadPend_q <= 1'b1;
            nvmWrite_q <= 1'b0;
        end
        else
        begin
            nvmWrite_q <= 1'b0;
            if (loadPend_q)
            begin
                voutSet_q <= nvmVoutStored;
                loadPend_q <= 1'b0;
            end
            else if (busStop && writeOk)
            begin
                voutSet_q <= {dataHi_q, dataLo_q};
                nvmWrite_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Alert and pin outputs
    // ****************************************************************
    logic alertOe_q, lowDrive_q;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            alertOe_q <= 1'b0;
            lowDrive_q <= 1'b0;
        end
        else
        begin
            alertOe_q <= alarmActive;
            lowDrive_q <= 1'b0;
        end
    end

    assign sdaOut = lowDrive_q;
    assign sdaOe = sdaOe_q;
    assign alert_lineOut = lowDrive_q;
    assign alert_lineOe = alertOe_q;
    assign nvmWrite = nvmWrite_q;
    assign nvmWriteData = voutSet_q;
    assign voutSetpoint = voutSet_q;

endmodule

`default_nettype wire

/* File: include/pmlf_pkg.sv */
// Constants, command codes and linear-format helpers for the management target
package pmlf_pkg;

    // ****************************************************************
    // Addressing and command codes
    // ****************************************************************
    localparam logic [6:0] ADDR_BASE = 7'h10;
    localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
    localparam logic [7:0] CMD_VOUT_COMMAND = 8'h21;
    localparam logic [7:0] CMD_START_VIN = 8'hD8;
    localparam logic [7:0] CMD_START_RC = 8'hD9;

    // ****************************************************************
    // Format fields
    // ****************************************************************
    localparam logic [2:0] VOUT_MODE_LINEAR = 3'h0;
    localparam logic [4:0] VOUT_EXP = 5'h17;
    localparam logic [4:0] EXP_START_VIN = 5'h06;
    localparam logic [4:0] EXP_START_RC = 5'h02;
    localparam logic [10:0] MANT_MAX = 11'h3FF;
    localparam logic [15:0] VOUT_RESET = 16'h0000;
    localparam logic [15:0] NO_DATA = 16'hFFFF;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned HOLDOFF_US = 300;
    localparam int unsigned HOLDOFF_CYCLES = HOLDOFF_US * CLK_MHZ;

    // Byte positions inside a frame, address byte first
    localparam logic [2:0] IDX_ADDR = 3'h0;
    localparam logic [2:0] IDX_CMD = 3'h1;
    localparam logic [2:0] IDX_LO = 3'h2;
    localparam logic [2:0] IDX_HI = 3'h3;
    localparam logic [2:0] IDX_PEC = 3'h4;
    localparam logic [2:0] IDX_AFTER_PEC = 3'h5;
    localparam logic [2:0] IDX_MAX = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RXACK,
        ST_TX,
        ST_TXACK
    } pmlf_state_t;

    // Exponent in 15:11, mantissa in 10:0
    function automatic logic [15:0] linPack(input logic [4:0] expo, input logic [10:0] mant);
        linPack = {expo, mant};
    endfunction

    // Milliseconds to mantissa for a fixed positive exponent, clipped to the positive range
    function automatic logic [10:0] msToMant(input logic [15:0] ms, input logic [4:0] expo);
        logic [15:0] q;
        q = ms >> expo;
        msToMant = (q > {5'h00, MANT_MAX}) ? MANT_MAX : q[10:0];
    endfunction

    function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++)
        begin
            c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        crc8 = c;
    endfunction

endpackage

/* File: tb/pmlf_target_checker.sv */
// Port-level concurrent checks for the management target
`timescale 1ns/1ps
`default_nettype none
module pmlf_target_checker
#(
    parameter int unsigned HOLDOFF_CYC = 15000
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic alert_lineOut,
    input wire logic alert_lineOe,
    input wire logic alarmActive,
    input wire logic nvmWrite,
    input wire logic [15:0] nvmWriteData,
    input wire logic [15:0] voutSetpoint
);
    logic [31:0] sinceStop_q;
    logic [31:0] startGap_q;
    // ****************************************************************
    // Bus events on the raw lines
    // ****************************************************************
    // Target sees them later through its synchroniser, same lag both ends
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            sinceStop_q <= 32'hffff_ffff;
        else if (sclIn && $rose(sdaIn))
            sinceStop_q <= 32'h0000_0000;
        else if (sinceStop_q != 32'hffff_ffff)
            sinceStop_q <= sinceStop_q + 32'h0000_0001;
    end
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            startGap_q <= 32'hffff_ffff;
        else if (sclIn && $fell(sdaIn))
            startGap_q <= sinceStop_q;
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_alert_raise: assert property (alarmActive |=> alert_lineOe) else $error("alert not raised");
    a_alert_drop: assert property (!alarmActive |=> !alert_lineOe) else $error("alert not dropped");
    a_alert_pull: assert property (alert_lineOe |-> !alert_lineOut) else $error("alert drives high");
    a_data_pull: assert property (sdaOe |-> !sdaOut) else $error("data drives high");
    a_drive_low_clock: assert property ($rose(sdaOe) |-> !sclIn) else $error("data driven in clock high");
    a_store_pulse: assert property (nvmWrite |=> !nvmWrite) else $error("store pulse too long");
    a_store_copy: assert property (nvmWrite |-> nvmWriteData == voutSetpoint) else $error("store data wrong");
    a_setpoint_cause: assert property ($changed(voutSetpoint) |-> nvmWrite || $past(sys_rst) ||
        $past(sys_rst, 2)) else $error("setpoint changed without commit");
    a_commit_idle: assert property (nvmWrite |-> sclIn && sdaIn) else $error("commit before stop");
    a_pacing_guard: assert property ($rose(sdaOe) |-> startGap_q >= HOLDOFF_CYC) else $error("answered early");
endmodule
bind pmlf_target pmlf_target_checker #(.HOLDOFF_CYC(HOLDOFF_CYC)) chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .alert_lineOut(alert_lineOut),
    .alert_lineOe(alert_lineOe), .alarmActive(alarmActive), .nvmWrite(nvmWrite), .nvmWriteData(nvmWriteData),
    .voutSetpoint(voutSetpoint));
`default_nettype wire

/* File: tb/pmlf_host_model.sv */
// Behavioural bus host driving clock and data of the target
`timescale 1ns/1ps
`default_nettype none
module pmlf_host_model
#(
    parameter int HALF = 12
)
(
    input wire logic clk_sys,
    input wire logic sclWire,
    input wire logic sdaWire,
    output var logic sclLow,
    output var logic sdaLow,
    output var logic resStb,
    output var logic [7:0] resByte
);
    initial
    begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
        resStb = 1'b0;
        resByte = 8'h00;
    end
    task automatic halfBit;
        repeat (HALF) @(negedge clk_sys);
    endtask
    // One clock: low half, release, high half, sample, fall
    task automatic pulse(output logic seen);
        int guard;
        guard = 0;
        halfBit();
        sclLow = 1'b0;
        @(negedge clk_sys);
        while (!sclWire && guard < 1000)
        begin
            @(negedge clk_sys);
            guard++;
        end
        repeat (HALF - 1) @(negedge clk_sys);
        seen = sdaWire;
        sclLow = 1'b1;
    endtask
    task automatic startC;
        sdaLow = 1'b0;
        halfBit();
        sclLow = 1'b0;
        halfBit();
        sdaLow = 1'b1;
        halfBit();
        sclLow = 1'b1;
    endtask
    task automatic stopC(input int gap);
        sdaLow = 1'b1;
        halfBit();
        sclLow = 1'b0;
        halfBit();
        sdaLow = 1'b0;
        repeat (gap) @(negedge clk_sys);
    endtask
    task automatic wrByte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--)
        begin
            sdaLow = ~b[i];
            pulse(seen);
        end
        sdaLow = 1'b0;
        pulse(seen);
        ack = ~seen;
    endtask
    task automatic rdByte(input logic last);
        logic seen;
        sdaLow = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            pulse(seen);
            resByte[i] = seen;
        end
        sdaLow = ~last;
        pulse(seen);
        sdaLow = 1'b0;
        resStb = 1'b1;
        @(negedge clk_sys);
        resStb = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: tb/pmbus_linear_format_addressing_bench.sv */
// Self-checking bench for the management target
`timescale 1ns/1ps
`default_nettype none
module pmbus_linear_format_addressing_bench;
    import pmlf_pkg::*;
    localparam int HOLD = 50;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] straps = 3'h0;
    logic alarmActive = 1'b0;
    logic [15:0] startVinMs = 16'h0000;
    logic [15:0] startRcMs = 16'h0000;
    logic [15:0] nvmVoutStored = 16'h0000;
    logic [15:0] expVout;
    logic [7:0] pec;
    logic [7:0] expQ[$];
    int failCount = 0;
    int nTests = 0;
    int nvmCount = 0;
    logic [15:0] storedWord = 16'h0000;
    wire logic sdaOut, sdaOe, alertOut, alertOe, nvmWrite, sclLow, hostSdaLow, resStb;
    wire logic [15:0] nvmWriteData, voutSetpoint;
    wire logic [7:0] resByte;
    // Both lines pulled up; target never stretches so clock follows the host
    wire logic sclWire = ~sclLow;
    wire logic sdaWire = ~(hostSdaLow | sdaOe);
    always #10 clk_sys = ~clk_sys;
    pmlf_target #(.HOLDOFF_CYC(HOLD)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .sclIn(sclWire),
        .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .strap_bit_zero(straps[0]), .strap_bit_one(straps[1]),
        .strap_bit_two(straps[2]), .alert_lineOut(alertOut), .alert_lineOe(alertOe), .alarmActive(alarmActive),
        .startVinMs(startVinMs), .startRcMs(startRcMs), .nvmVoutStored(nvmVoutStored), .nvmWrite(nvmWrite),
        .nvmWriteData(nvmWriteData), .voutSetpoint(voutSetpoint));
    pmlf_host_model #(.HALF(4)) host_u (.clk_sys(clk_sys), .sclWire(sclWire), .sdaWire(sdaWire),
        .sclLow(sclLow), .sdaLow(hostSdaLow), .resStb(resStb), .resByte(resByte));
    // ****************************************************************
    // Checking and reporting
    // ****************************************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            failCount++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic testDone;
        $display("Comparisons %0d, mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge resStb)
        check("read byte", {8'h00, resByte}, expQ.size() ? {8'h00, expQ.pop_front()} : 16'hdead);
    // Sampled away from the launching edge so the pulse is settled
    always @(negedge clk_sys)
        if (nvmWrite === 1'b1)
        begin
            nvmCount++;
            storedWord = nvmWriteData;
        end
    function automatic logic [7:0] pecStep(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++)
            r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
        return r;
    endfunction
    function automatic logic [10:0] clip(input logic [15:0] q);
        return (q > 16'h03ff) ? 11'h3ff : q[10:0];
    endfunction
    // ****************************************************************
    // Transactions
    // ****************************************************************
    task automatic send(input logic [7:0] b, input logic expAck);
        logic ack;
        host_u.wrByte(b, ack);
        pec = pecStep(pec, b);
        check("ack", {15'h0000, ack}, {15'h0000, expAck});
    endtask
    task automatic doReset(input logic [2:0] s);
        sys_rst = 1'b1;
        straps = s;
        nvmVoutStored = 16'($urandom);
        expVout = nvmVoutStored;
        repeat (5) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (5) @(negedge clk_sys);
        check("restored setpoint", voutSetpoint, expVout);
    endtask
    task automatic writeVout(input logic [6:0] a, input logic [15:0] w, input logic good, input int gap);
        int cnt0;
        cnt0 = nvmCount;
        pec = 8'h00;
        host_u.startC();
        send({a, 1'b0}, 1'b1);
        send(CMD_VOUT_COMMAND, 1'b1);
        send(w[7:0], 1'b1);
        send(w[15:8], 1'b1);
        send(pec ^ {7'h00, ~good}, 1'b1);
        host_u.stopC(gap);
        if (good)
            expVout = w;
        check("setpoint", voutSetpoint, expVout);
        check("store pulses", 16'(nvmCount - cnt0), {15'h0000, good});
        check("stored word", storedWord, expVout);
    endtask
    task automatic readCmd(input logic [6:0] a, input logic [7:0] cmd, input int n, input logic [15:0] w);
        logic [7:0] b;
        pec = 8'h00;
        host_u.startC();
        send({a, 1'b0}, 1'b1);
        send(cmd, 1'b1);
        host_u.startC();
        send({a, 1'b1}, 1'b1);
        for (int i = 0; i <= n; i++)
        begin
            b = (i == n) ? pec : w[8*i +: 8];
            expQ.push_back(b);
            pec = pecStep(pec, b);
            host_u.rdByte(i == n);
        end
        host_u.stopC(HOLD + 10);
    endtask
    task automatic missAddr(input logic [6:0] a);
        host_u.startC();
        send({a, 1'b0}, 1'b0);
        host_u.stopC(HOLD + 10);
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [6:0] me;
        int seed;
        seed = $urandom(32'h8a67_2b1a);
        for (int s = 0; s < 8; s++)
        begin
            doReset(s[2:0]);
            readCmd(7'(16 + s), CMD_VOUT_MODE, 1, {8'h00, 3'b000, VOUT_EXP});
            missAddr(7'(16 + ((s + 1) % 8)));
        end
        doReset(3'($urandom));
        me = {4'b0010, straps};
        missAddr(7'h18);
        for (int k = 0; k < 6; k++)
        begin
            alarmActive = 1'($urandom);
            repeat (2) @(negedge clk_sys);
            check("alert", {15'h0000, alertOe}, {15'h0000, alarmActive});
            writeVout(me, 16'($urandom), k != 2, HOLD + 10);
            readCmd(me, CMD_VOUT_COMMAND, 2, expVout);
            startVinMs = 16'($urandom);
            startRcMs = 16'($urandom);
            readCmd(me, CMD_START_VIN, 2, {5'h06, clip(startVinMs >> 6)});
            readCmd(me, CMD_START_RC, 2, {5'h02, clip(startRcMs >> 2)});
        end
        writeVout(me, 16'($urandom), 1'b1, 8);
        missAddr(me);
        readCmd(me, CMD_VOUT_MODE, 1, {8'h00, 3'b000, VOUT_EXP});
        readCmd(me, 8'h5A, 2, 16'hffff);
        testDone();
    end
    initial
    begin
        repeat (50000) @(posedge clk_sys);
        failCount++;
        $display("unexpected watchdog: expected end seen hang");
        testDone();
    end
endmodule
`default_nettype wire
